// *** hw/splp_pkg.sv ***
// Shared constants, register map, commands and types for the sector protection lock block
package splp_pkg;
   // Clock and timing
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned UNLOCK_DELAY_US = 100;
   localparam int unsigned UNLOCK_TOL_US = 20;
   localparam int unsigned UNLOCK_CYCLES = UNLOCK_DELAY_US * CLK_MHZ;
   localparam int unsigned PGM_CYCLES = 16;
   localparam int unsigned NUM_SECTORS = 256;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [5:0] OFS_CMD = 6'h00;
   localparam logic [5:0] OFS_ARG = 6'h04;
   localparam logic [5:0] OFS_DATA_LO = 6'h08;
   localparam logic [5:0] OFS_DATA_HI = 6'h0c;
   localparam logic [5:0] OFS_STATUS = 6'h10;
   localparam logic [5:0] OFS_MODE = 6'h14;
   localparam logic [5:0] OFS_PW_LO = 6'h18;
   localparam logic [5:0] OFS_PW_HI = 6'h1c;
   localparam logic [5:0] OFS_SECTOR = 6'h20;

   // Command codes written to the low nibble of the command register
   localparam logic [3:0] CMD_CLR_LOCK = 4'h1;
   localparam logic [3:0] CMD_PGM_PERS = 4'h2;
   localparam logic [3:0] CMD_ERASE_PERS = 4'h3;
   localparam logic [3:0] CMD_WRITE_VOL = 4'h4;
   localparam logic [3:0] CMD_PGM_PW = 4'h5;
   localparam logic [3:0] CMD_UNLOCK = 4'h6;
   localparam logic [3:0] CMD_PGM_MODE = 4'h7;
   localparam logic [3:0] CMD_SW_RESET = 4'h8;
   localparam logic [3:0] CMD_CLR_ERR = 4'h9;

   // Field positions
   localparam int unsigned ARG_VAL_BIT = 8;
   localparam int unsigned MODE_PERS_BIT = 1;
   localparam int unsigned MODE_PW_BIT = 2;

   // Reset values
   localparam logic [2:0] MODE_RST = 3'h7;
   localparam logic [63:0] PW_RST = 64'hffff_ffff_ffff_ffff;

   // Status word, low bits first: busy, program error, protection error, lock, password mode
   typedef struct packed {
      logic pw_mode;
      logic lock;
      logic prot_err;
      logic prog_err;
      logic busy;
   } splp_status_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PGM = 3'b010,
      ST_UNLK = 3'b100
   } splp_state_e;
endpackage : splp_pkg

// *** hw/splp_core.sv ***
// Sector protection lock and password unlock logic with an Avalon-MM register slave
// Behaviour
// - A volatile lock bit guards all persistent bits; 0 blocks changes, 1 allows.
// - Persistent program or erase fails unchanged while the lock bit is 0.
// - Persistent mode sets the lock bit to 1 at power-up and hardware reset.
// - Persistent mode: once lock is 0 no command returns it to 1.
// - Password mode clears lock at power-up and reset; only unlock sets it. Here power-up reloads persistent mode and sets lock to 1.
// - Volatile bits return to unprotected after power cycle, software or hardware reset.
// - A sector is unprotected only when persistent and volatile bits are both 1.
// - Volatile bits change regardless of lock; persistent bits only while lock is 1.
// - Software reset leaves the lock bit unchanged in persistent mode.
// - A command clears the lock bit; none sets it in persistent mode.
// - Password mode: matching full 64-bit password unlock sets the lock bit.
// - Password sits in its own space, reset to all ones, program and read commands.
// - After mode register bit 2 is programmed 0, password program and read ignored.
// - Password programming only clears cells; a 1 over a 0 stays 0, no error.
// - Mode register bits are one-time programmable and never erased. Here power-up reset reloads MODE_RST.
// - Password mismatch sets program and protection errors and keeps lock at 0.
// - Unlock accepted at most once per 100 us; busy stays 1 meanwhile.
// - A correct password clears busy without the rate-limiting delay.
// - Any 64-bit value is a legal password.
// - Persistent bits are programmed to 0 singly and erased to 1 all together.
// - Volatile write sets 0 to protect, 1 to unprotect; effective where persistent is 1.
module splp_core #(
   parameter int unsigned NUM_SECTORS = splp_pkg::NUM_SECTORS,
   parameter int unsigned UNLOCK_CYCLES = splp_pkg::UNLOCK_CYCLES,
   parameter int unsigned PGM_CYCLES = splp_pkg::PGM_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic hw_rst_n_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [NUM_SECTORS-1:0] sector_unprot_o,
   output logic lock_o,
   output logic write_in_progress_flag_o,
   output logic password_mode_o
);
   localparam int unsigned SW = $clog2(NUM_SECTORS);
   localparam int unsigned MAXC = (UNLOCK_CYCLES > PGM_CYCLES) ? UNLOCK_CYCLES : PGM_CYCLES;
   localparam int unsigned CW = $clog2(MAXC + 1);

   // Storage and control state
   logic ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic hw_meta_r;
   logic hw_sync_r;
   logic lock_r;
   logic prog_err_r;
   logic prot_err_r;
   logic [NUM_SECTORS-1:0] persistent_protect_bit_r;
   logic [NUM_SECTORS-1:0] volatile_protect_bit_r;
   logic [NUM_SECTORS-1:0] unprot_r;
   logic [63:0] password_r;
   logic [2:0] protection_mode_register_r;
   logic [31:0] data_lo_r;
   logic [31:0] data_hi_r;
   logic [31:0] arg_r;
   logic [CW-1:0] cnt_r;
   splp_pkg::splp_state_e state_r;
   splp_pkg::splp_status_s status;

   // Decoded strobes
   logic hw_rst_act;
   logic wr_fire;
   logic cmd_go;
   logic [3:0] cmd;
   logic [SW-1:0] sec_idx;
   logic pw_mode;
   logic pw_locked;
   logic pw_match;
   logic unlock_go;
   logic pers_change;
   logic pers_fail;
   logic pw_fail;
   logic err_set;

   // Avalon answer: every access waits exactly one cycle so read data can be registered
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
   assign avs_readdata_o = rdata_r;

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
   end

   // Hardware reset pin is asynchronous to mclk_i, so it passes two flops first
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hw_meta_r <= 1'b1;
         hw_sync_r <= 1'b1;
      end
      else
      begin
         hw_meta_r <= hw_rst_n_i;
         hw_sync_r <= hw_meta_r;
      end
   end

   assign hw_rst_act = ~hw_sync_r;
   assign wr_fire = avs_write_i & ack_r;
   assign cmd = avs_writedata_i[3:0];
   // Commands are only taken while idle; a command issued during busy is dropped
   assign cmd_go = wr_fire & (avs_address_i == splp_pkg::OFS_CMD) & avs_byteenable_i[0]
                   & (state_r == splp_pkg::ST_IDLE) & ~hw_rst_act;
   assign sec_idx = arg_r[SW-1:0];
   assign pw_mode = ~protection_mode_register_r[splp_pkg::MODE_PW_BIT];
   assign pw_locked = ~protection_mode_register_r[splp_pkg::MODE_PW_BIT];
   // Every 64-bit pattern is compared as-is, with no reserved values
   assign pw_match = ({data_hi_r, data_lo_r} == password_r);
   assign unlock_go = cmd_go & (cmd == splp_pkg::CMD_UNLOCK) & pw_mode;
   assign pers_change = cmd_go & ((cmd == splp_pkg::CMD_PGM_PERS) | (cmd == splp_pkg::CMD_ERASE_PERS));
   assign pers_fail = pers_change & ~lock_r;
   assign pw_fail = unlock_go & ~pw_match;
   assign err_set = pers_fail | pw_fail;

   // Lock bit: reset value follows the mode, only unlock may raise it in password mode
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lock_r <= 1'b1;
      else if (hw_rst_act)
         lock_r <= protection_mode_register_r[splp_pkg::MODE_PW_BIT];
      else if (cmd_go & (cmd == splp_pkg::CMD_CLR_LOCK))
         lock_r <= 1'b0;
      else if (unlock_go & pw_match)
         lock_r <= 1'b1;
   end

   // Error flags are sticky; a new error beats a clear in the same cycle
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prog_err_r <= 1'b0;
         prot_err_r <= 1'b0;
      end
      else if (hw_rst_act)
      begin
         prog_err_r <= 1'b0;
         prot_err_r <= 1'b0;
      end
      else if (err_set)
      begin
         prog_err_r <= 1'b1;
         prot_err_r <= 1'b1;
      end
      else if (cmd_go & (cmd == splp_pkg::CMD_CLR_ERR))
      begin
         prog_err_r <= 1'b0;
         prot_err_r <= 1'b0;
      end
   end

   // Volatile bits come up unprotected and can be written at any lock state
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         volatile_protect_bit_r <= '1;
      else if (hw_rst_act | (cmd_go & (cmd == splp_pkg::CMD_SW_RESET)))
         volatile_protect_bit_r <= '1;
      else if (cmd_go & (cmd == splp_pkg::CMD_WRITE_VOL))
         volatile_protect_bit_r[sec_idx] <= arg_r[splp_pkg::ARG_VAL_BIT];
   end

   // Persistent bits survive hardware reset; power-up, or the erase command while lock is 1, returns them to erased
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         persistent_protect_bit_r <= '1;
      else if (pers_change & lock_r & (cmd == splp_pkg::CMD_ERASE_PERS))
         persistent_protect_bit_r <= '1;
      else if (pers_change & lock_r)
         persistent_protect_bit_r[sec_idx] <= 1'b0;
   end

   // Per-sector protection state, registered so the output vector is glitch free
   genvar g;
   generate
      for (g = 0; g < NUM_SECTORS; g++)
      begin : g_sec
         always_ff @(posedge mclk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               unprot_r[g] <= 1'b1;
            else
               unprot_r[g] <= persistent_protect_bit_r[g] & volatile_protect_bit_r[g];
         end
      end
   endgenerate

   assign sector_unprot_o = unprot_r;

   // Password space: programming can only clear cells, and it closes once the mode locks
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         password_r <= splp_pkg::PW_RST;
      else if (cmd_go & (cmd == splp_pkg::CMD_PGM_PW) & ~pw_locked)
         password_r <= password_r & {data_hi_r, data_lo_r};
   end

   // Mode bits are one-time programmable: AND only, only the power-up reset sets them back to MODE_RST
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         protection_mode_register_r <= splp_pkg::MODE_RST;
      else if (cmd_go & (cmd == splp_pkg::CMD_PGM_MODE))
         protection_mode_register_r <= protection_mode_register_r
                                       & {data_lo_r[2:1], 1'b1};
   end

   // Argument and data words, honouring byte enables
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         arg_r <= 32'h0000_0000;
         data_lo_r <= 32'h0000_0000;
         data_hi_r <= 32'h0000_0000;
      end
      else if (wr_fire)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (avs_byteenable_i[b])
            begin
               if (avs_address_i == splp_pkg::OFS_ARG)
                  arg_r[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
               if (avs_address_i == splp_pkg::OFS_DATA_LO)
                  data_lo_r[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
               if (avs_address_i == splp_pkg::OFS_DATA_HI)
                  data_hi_r[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
            end
         end
      end
   end

   // Busy sequencer; a failed unlock holds busy for the full delay to slow guessing
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= splp_pkg::ST_IDLE;
         cnt_r <= '0;
      end
      else if (hw_rst_act)
      begin
         state_r <= splp_pkg::ST_IDLE;
         cnt_r <= '0;
      end
      else
      begin
         case (state_r)
            splp_pkg::ST_IDLE:
            begin
               if (unlock_go & pw_match)
               begin
                  state_r <= splp_pkg::ST_UNLK;
                  cnt_r <= '0;
               end
               else if (unlock_go)
               begin
                  state_r <= splp_pkg::ST_UNLK;
                  cnt_r <= CW'(UNLOCK_CYCLES - 1);
               end
               else if ((pers_change & lock_r) | (cmd_go & ((cmd == splp_pkg::CMD_PGM_MODE)
                        | ((cmd == splp_pkg::CMD_PGM_PW) & ~pw_locked))))
               begin
                  state_r <= splp_pkg::ST_PGM;
                  cnt_r <= CW'(PGM_CYCLES - 1);
               end
            end
            splp_pkg::ST_PGM,
            splp_pkg::ST_UNLK:
            begin
               if (cnt_r == '0)
                  state_r <= splp_pkg::ST_IDLE;
               else
                  cnt_r <= cnt_r - 1'b1;
            end
            default:
            begin
               state_r <= splp_pkg::ST_IDLE;
               cnt_r <= '0;
            end
         endcase
      end
   end

   // Status word gathered in its carrier
   always_comb
   begin
      status.pw_mode = pw_mode;
      status.lock = lock_r;
      status.prot_err = prot_err_r;
      status.prog_err = prog_err_r;
      status.busy = (state_r != splp_pkg::ST_IDLE);
   end

   assign lock_o = lock_r;
   assign write_in_progress_flag_o = status.busy;
   assign password_mode_o = pw_mode;

   // Read mux; unmapped offsets and a locked password region read as zero
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address_i)
         splp_pkg::OFS_ARG: rdata_nxt = arg_r;
         splp_pkg::OFS_DATA_LO: rdata_nxt = data_lo_r;
         splp_pkg::OFS_DATA_HI: rdata_nxt = data_hi_r;
         splp_pkg::OFS_STATUS: rdata_nxt = {27'h0, status};
         splp_pkg::OFS_MODE: rdata_nxt = {29'h0, protection_mode_register_r};
         splp_pkg::OFS_PW_LO: rdata_nxt = pw_locked ? 32'h0000_0000 : password_r[31:0];
         splp_pkg::OFS_PW_HI: rdata_nxt = pw_locked ? 32'h0000_0000 : password_r[63:32];
         splp_pkg::OFS_SECTOR: rdata_nxt = {29'h0, unprot_r[sec_idx], volatile_protect_bit_r[sec_idx],
                                            persistent_protect_bit_r[sec_idx]};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Read data is loaded in the wait cycle so it stands at the answering edge
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_r <= 32'h0000_0000;
      else if (avs_read_i & ~ack_r)
         rdata_r <= rdata_nxt;
   end
endmodule : splp_core

// *** test/splp_checker.sv ***
// Concurrent checks on the ports of the sector protection lock block
module splp_checker #(
   parameter int unsigned NUM_SECTORS = 8,
   parameter int unsigned UNLOCK_CYCLES = 20
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic hw_rst_n_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic [NUM_SECTORS-1:0] sector_unprot_o,
   input wire logic lock_o,
   input wire logic write_in_progress_flag_o,
   input wire logic password_mode_o
);
   // Longest busy allowed: nominal rate limit plus its tolerance
   localparam int BUSY_MAX = UNLOCK_CYCLES + UNLOCK_CYCLES / 5;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Command write taken while idle; the reset pin reaches the logic two edges late through its synchroniser
   sequence s_cmd(code);
      avs_write_i && !avs_waitrequest_o && avs_address_i == splp_pkg::OFS_CMD && avs_byteenable_i[0]
         && avs_writedata_i[3:0] == code && !write_in_progress_flag_o && $past(hw_rst_n_i, 2);
   endsequence
   property p_hw_lock; !hw_rst_n_i [*5] |-> lock_o == !password_mode_o && !write_in_progress_flag_o; endproperty
   property p_lock_stays; !password_mode_o && !lock_o && hw_rst_n_i |=> !lock_o; endproperty
   property p_pw_lock;
      password_mode_o && $rose(lock_o) |-> write_in_progress_flag_o || $past(write_in_progress_flag_o);
   endproperty
   property p_busy_bound; $rose(write_in_progress_flag_o) |-> ##[1:BUSY_MAX] !write_in_progress_flag_o; endproperty
   property p_clr; s_cmd(splp_pkg::CMD_CLR_LOCK) |=> !lock_o; endproperty
   property p_swrst; s_cmd(splp_pkg::CMD_SW_RESET) |=> $stable(lock_o); endproperty
   property p_unlock_busy; s_cmd(splp_pkg::CMD_UNLOCK) ##0 password_mode_o |=> write_in_progress_flag_o; endproperty
   property p_pers_refused;
      s_cmd(splp_pkg::CMD_PGM_PERS) ##0 !lock_o |=> (!write_in_progress_flag_o && $stable(sector_unprot_o)) [*2];
   endproperty
   a_hw_lock: assert property (p_hw_lock) else $error("lock wrong in hw reset");
   a_lock_stays: assert property (p_lock_stays) else $error("lock set by software");
   a_pw_lock: assert property (p_pw_lock) else $error("lock set without unlock");
   a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
   a_clr: assert property (p_clr) else $error("lock not cleared");
   a_swrst: assert property (p_swrst) else $error("lock moved by sw reset");
   a_unlock_busy: assert property (p_unlock_busy) else $error("unlock not busy");
   a_pers_refused: assert property (p_pers_refused) else $error("locked persistent bit changed");
endmodule : splp_checker

bind splp_core splp_checker #(.NUM_SECTORS(NUM_SECTORS), .UNLOCK_CYCLES(UNLOCK_CYCLES)) u_chk (
   .mclk_i(mclk_i),
   .rst_n_i(rst_n_i),
   .hw_rst_n_i(hw_rst_n_i),
   .avs_address_i(avs_address_i),
   .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i),
   .avs_waitrequest_o(avs_waitrequest_o),
   .sector_unprot_o(sector_unprot_o),
   .lock_o(lock_o),
   .write_in_progress_flag_o(write_in_progress_flag_o),
   .password_mode_o(password_mode_o)
);

// *** test/splp_host.sv ***
// Register bus master standing in for the host controller
module splp_host (
   input wire logic mclk_i,
   input wire logic waitreq_i,
   input wire logic [31:0] rdata_i,
   output logic [5:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [31:0] wdata_o,
   output logic [3:0] be_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle from time zero
   initial
   begin
      addr_o = 6'h3f;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 32'h0;
      be_o = 4'hf;
   end
   // One access, held until waitrequest is seen low at a rising edge
   task automatic access(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk_i);
      addr_o <= a;
      wr_o <= w;
      rd_o <= !w;
      wdata_o <= d;
      @(posedge mclk_i);
      while (waitreq_i !== 1'b0)
         @(posedge mclk_i);
      q = rdata_i;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      addr_o <= ~a; // Released bus carries junk, so a stale value can never pass
      wdata_o <= ~d;
   endtask : access
   // Status polled until busy clears before the next command
   task automatic poll_idle();
      logic [31:0] q;
      do
         access(1'b0, splp_pkg::OFS_STATUS, 32'h0, q);
      while (q[0] !== 1'b0);
   endtask : poll_idle
endmodule : splp_host

// *** test/test_splp_core.sv ***
// Self-checking bench for the sector protection lock block
module test_splp_core;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned NS = 8;
   localparam int unsigned UC = 20;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic hw_rst_n_i = 1'b1;
   logic [5:0] addr;
   logic rd, wr, waitreq, lock_o, busy, pwm;
   logic [31:0] wdata, rdata;
   logic [3:0] be;
   logic [NS-1:0] unprot;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;

   splp_core #(.NUM_SECTORS(NS), .UNLOCK_CYCLES(UC), .PGM_CYCLES(4)) uut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hw_rst_n_i(hw_rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .sector_unprot_o(unprot), .lock_o(lock_o),
      .write_in_progress_flag_o(busy), .password_mode_o(pwm));
   splp_host u_host (.mclk_i(mclk_i), .waitreq_i(waitreq), .rdata_i(rdata), .addr_o(addr), .rd_o(rd),
      .wr_o(wr), .wdata_o(wdata), .be_o(be));

   // 100 MHz clock
   always #5 mclk_i = ~mclk_i;

   task automatic end_sim();
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_host.access(1'b1, a, d, q);
   endtask : wr_reg
   task automatic rd_reg(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] q;
      u_host.access(1'b0, a, 32'h0, q);
      chk(q & m, exp);
   endtask : rd_reg
   // Argument, command, then wait for the block to go idle
   task automatic op(input logic [31:0] arg, input logic [3:0] c);
      wr_reg(splp_pkg::OFS_ARG, arg);
      wr_reg(splp_pkg::OFS_CMD, {28'h0, c});
      u_host.poll_idle();
   endtask : op
   task automatic hw_reset();
      @(posedge mclk_i);
      hw_rst_n_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      hw_rst_n_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
   endtask : hw_reset
   // Unlock issued, then busy cycles counted
   task automatic unlock(input logic [31:0] lo, output int cnt);
      wr_reg(splp_pkg::OFS_DATA_LO, lo);
      wr_reg(splp_pkg::OFS_CMD, {28'h0, splp_pkg::CMD_UNLOCK});
      cnt = 0;
      @(posedge mclk_i);
      while (busy === 1'b1)
      begin
         cnt++;
         @(posedge mclk_i);
      end
   endtask : unlock

   // Hang guard
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end

   initial
   begin
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      chk({31'h0, lock_o}, 32'h1);
      chk({24'h0, unprot}, 32'hff);
      rd_reg(splp_pkg::OFS_STATUS, 32'h08, 32'h1f);
      rd_reg(splp_pkg::OFS_PW_LO, 32'hffffffff, 32'hffffffff);
      rd_reg(splp_pkg::OFS_MODE, 32'h7, 32'h7);
      rd_reg(6'h3c, 32'h0, 32'hffffffff);
      op(32'h002, splp_pkg::CMD_WRITE_VOL);
      chk({24'h0, unprot}, 32'hfb);
      op(32'h005, splp_pkg::CMD_PGM_PERS);
      chk({24'h0, unprot}, 32'hdb);
      op(32'h102, splp_pkg::CMD_WRITE_VOL);
      op(32'h105, splp_pkg::CMD_WRITE_VOL);
      chk({24'h0, unprot}, 32'hdf);
      rd_reg(splp_pkg::OFS_SECTOR, 32'h2, 32'h7);
      op(32'h001, splp_pkg::CMD_WRITE_VOL);
      op(32'h0, splp_pkg::CMD_SW_RESET);
      chk({24'h0, unprot}, 32'hdf);
      op(32'h0, splp_pkg::CMD_ERASE_PERS);
      chk({24'h0, unprot}, 32'hff);
      // Persistent bits configured before the lock is dropped
      op(32'h006, splp_pkg::CMD_PGM_PERS);
      op(32'h0, splp_pkg::CMD_CLR_LOCK);
      chk({31'h0, lock_o}, 32'h0);
      op(32'h003, splp_pkg::CMD_PGM_PERS);
      op(32'h0, splp_pkg::CMD_ERASE_PERS);
      rd_reg(splp_pkg::OFS_STATUS, 32'h06, 32'h1f);
      chk({24'h0, unprot}, 32'hbf);
      op(32'h000, splp_pkg::CMD_WRITE_VOL);
      chk({24'h0, unprot}, 32'hbe);
      op(32'h0, splp_pkg::CMD_SW_RESET);
      op(32'h0, splp_pkg::CMD_UNLOCK);
      chk({31'h0, lock_o}, 32'h0);
      // Sector 1 protected again so the hardware reset has something to undo
      op(32'h001, splp_pkg::CMD_WRITE_VOL);
      chk({24'h0, unprot}, 32'hbd);
      hw_reset();
      chk({31'h0, lock_o}, 32'h1);
      chk({24'h0, unprot}, 32'hbf);
      // Password only ever loses ones
      wr_reg(splp_pkg::OFS_DATA_LO, 32'h89abcdef);
      wr_reg(splp_pkg::OFS_DATA_HI, 32'h01234567);
      op(32'h0, splp_pkg::CMD_PGM_PW);
      wr_reg(splp_pkg::OFS_DATA_LO, 32'hffffffff);
      wr_reg(splp_pkg::OFS_DATA_HI, 32'hffffffff);
      op(32'h0, splp_pkg::CMD_PGM_PW);
      rd_reg(splp_pkg::OFS_PW_LO, 32'h89abcdef, 32'hffffffff);
      rd_reg(splp_pkg::OFS_PW_HI, 32'h01234567, 32'hffffffff);
      rd_reg(splp_pkg::OFS_STATUS, 32'h08, 32'h1f);
      wr_reg(splp_pkg::OFS_DATA_LO, 32'h0);
      op(32'h0, splp_pkg::CMD_PGM_MODE);
      wr_reg(splp_pkg::OFS_DATA_LO, 32'hffffffff);
      op(32'h0, splp_pkg::CMD_PGM_MODE);
      rd_reg(splp_pkg::OFS_MODE, 32'h1, 32'h7);
      hw_reset();
      chk({30'h0, pwm, lock_o}, 32'h2);
      rd_reg(splp_pkg::OFS_PW_LO, 32'h0, 32'hffffffff);
      wr_reg(splp_pkg::OFS_DATA_LO, 32'h0);
      op(32'h0, splp_pkg::CMD_PGM_PW);
      wr_reg(splp_pkg::OFS_DATA_HI, 32'h01234567);
      unlock(32'h89abcdee, n);
      chk({31'h0, n >= UC * 4 / 5 && n <= UC * 6 / 5}, 32'h1);
      rd_reg(splp_pkg::OFS_STATUS, 32'h16, 32'h1f);
      op(32'h0, splp_pkg::CMD_CLR_ERR);
      unlock(32'h89abcdef, n);
      chk({31'h0, n <= 2}, 32'h1);
      rd_reg(splp_pkg::OFS_STATUS, 32'h18, 32'h1f);
      end_sim();
   end
endmodule : test_splp_core
